// ===== inc/clock_monitor_pkg.sv
// shared types and constants of the clock period monitor
package clock_monitor_pkg;

  // widths
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned STATUS_W = 8;

  // measurement step: one count per this many core clock cycles
  localparam int unsigned STEP_CYCLES = 9;
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYCLES - 1);
  localparam logic [3:0] STEP_ZERO = 4'h0;

  // no-signal watchdog limit, also the saturation value of the count
  localparam logic [COUNT_W-1:0] NOSIG_LIMIT = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  // outcome codes
  localparam logic [STATUS_W-1:0] STAT_PASS = 8'h00;
  localparam logic [STATUS_W-1:0] STAT_RANGE = 8'h01;
  localparam logic [STATUS_W-1:0] STAT_NOREF = 8'h02;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_SYNC      = 2'b01,
    ST_WAIT_HIGH = 2'b10,
    ST_MEASURE   = 2'b11
  } state_t;

  // window limits supplied by the controlling party
  typedef struct packed {
    logic [COUNT_W-1:0] lower_count_limit;
    logic [COUNT_W-1:0] upper_count_limit;
  } limits_t;

  // result of one measurement
  typedef struct packed {
    logic                done;
    logic [STATUS_W-1:0] status;
    logic [COUNT_W-1:0]  count;
  } result_t;

endpackage : clock_monitor_pkg

// ===== design/level_sync.sv
// two-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
module level_sync (
  input  wire logic core_clk,  // core clock
  input  wire logic arst_n,    // async reset, active low
  input  wire logic async_in,  // level from outside the domain
  output logic      sync_out   // synchronised level
);

  logic meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : level_sync

// ===== design/clock_period_monitor.sv
// clock period monitor: times one high phase of a reference input
//
// Notes on behaviour
// - before measuring, wait for the reference to fall high to low
// - then wait for a rise; the measurement count starts at that rise
// - count keeps going while reference is high; stops at next fall
// - at stop, compare final count with lower and upper limits
// - interval is one high phase, half the reference period
// - each count increment takes exactly nine core clock cycles
// - waits bump a no-signal counter; at NOSIG_CYCLES (0xFFFF by default) abort with no-reference
// - each detected awaited edge clears the counter to zero, unless the counter is at NOSIG_CYCLES then, when the abort wins
// - count not above lower limit reports range failure
// - count above upper limit reports range failure
// - count inside both limits reports status zero, pass
// - missing reference has its own status, distinct from range failure
`timescale 1ns/10ps
module clock_period_monitor
  import clock_monitor_pkg::*;
#(
  parameter logic [15:0] NOSIG_CYCLES = clock_monitor_pkg::NOSIG_LIMIT
) (
  input  wire logic                       core_clk,            // 100 MHz
  input  wire logic                       arst_n,              // async rst
  input  wire logic                       start,               // begin pulse
  input  wire clock_monitor_pkg::limits_t limits,              // window
  input  wire logic                       reference_input_pin, // ref pin
  output logic                            busy,                // measuring
  output clock_monitor_pkg::result_t      result               // outcome
);
  import clock_monitor_pkg::*;

  // saturating increment of a count
  function automatic logic [COUNT_W-1:0] sat_inc(
    input logic [COUNT_W-1:0] value
  );
    sat_inc = (value == NOSIG_LIMIT) ? value : value + 16'h0001;
  endfunction : sat_inc

  // window comparison of a finished count
  function automatic logic [STATUS_W-1:0] classify(
    input logic [COUNT_W-1:0] value,
    input limits_t            lim
  );
    if (value <= lim.lower_count_limit) begin
      classify = STAT_RANGE;
    end else if (value > lim.upper_count_limit) begin
      classify = STAT_RANGE;
    end else begin
      classify = STAT_PASS;
    end
  endfunction : classify

  logic                ref_sync;
  logic                ref_prev;
  logic                ref_fall;
  logic                ref_rise;
  state_t              state;
  state_t              next_state;
  logic [COUNT_W-1:0]  cnt;
  logic [COUNT_W-1:0]  next_cnt;
  logic [3:0]          pre;
  logic [3:0]          next_pre;
  logic                done;
  logic                next_done;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] next_status;
  logic [COUNT_W-1:0]  last_count;
  logic [COUNT_W-1:0]  next_last_count;
  logic                nosig;

  // pin crosses into the core clock domain
  level_sync u_ref_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (reference_input_pin),
    .sync_out (ref_sync)
  );

  // edge detection on the synchronised level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_sync;
    end
  end

  assign ref_fall = ref_prev & ~ref_sync;
  assign ref_rise = ~ref_prev & ref_sync;
  assign nosig    = (cnt == NOSIG_CYCLES);

  // sequencer next values
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_pre        = pre;
    next_done       = 1'b0;
    next_status     = status;
    next_last_count = last_count;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_SYNC;
          next_cnt   = COUNT_ZERO;
        end
      end
      ST_SYNC: begin
        if (nosig) begin
          next_state      = ST_IDLE;
          next_done       = 1'b1;
          next_status     = STAT_NOREF;
          next_last_count = cnt;
        end else if (ref_fall) begin
          next_state = ST_WAIT_HIGH;
          next_cnt   = COUNT_ZERO;
        end else begin
          next_cnt = sat_inc(cnt);
        end
      end
      ST_WAIT_HIGH: begin
        if (nosig) begin
          next_state      = ST_IDLE;
          next_done       = 1'b1;
          next_status     = STAT_NOREF;
          next_last_count = cnt;
        end else if (ref_rise) begin
          next_state = ST_MEASURE;
          next_cnt   = COUNT_ZERO;
          next_pre   = STEP_ZERO;
        end else begin
          next_cnt = sat_inc(cnt);
        end
      end
      ST_MEASURE: begin
        if (ref_fall) begin
          next_state      = ST_IDLE;
          next_done       = 1'b1;
          next_status     = classify(cnt, limits);
          next_last_count = cnt;
        end else if (pre == STEP_LAST) begin
          next_pre = STEP_ZERO;
          next_cnt = sat_inc(cnt);
        end else begin
          next_pre = pre + 4'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      cnt        <= COUNT_ZERO;
      pre        <= STEP_ZERO;
      done       <= 1'b0;
      status     <= STAT_PASS;
      last_count <= COUNT_ZERO;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      pre        <= next_pre;
      done       <= next_done;
      status     <= next_status;
      last_count <= next_last_count;
    end
  end

  // outputs
  assign busy   = (state != ST_IDLE);
  assign result = '{done: done, status: status, count: last_count};

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sync_wait_a: assert property (
    state == ST_SYNC && !ref_fall && !nosig |=> state == ST_SYNC)
    else $error("left sync wait without a falling edge");

  rise_start_a: assert property (
    state == ST_WAIT_HIGH && ref_rise && !nosig
    |=> state == ST_MEASURE && cnt == COUNT_ZERO && pre == STEP_ZERO)
    else $error("measurement did not start cleanly at rise");

  count_hold_a: assert property (
    state == ST_MEASURE && !ref_fall |=> state == ST_MEASURE)
    else $error("measurement ended without a falling edge");

  stop_done_a: assert property (
    state == ST_MEASURE && ref_fall
    |=> done && state == ST_IDLE && result.count == $past(cnt))
    else $error("fall in measurement did not finish with count");

  step_nine_a: assert property (
    state == ST_MEASURE && pre == STEP_ZERO && cnt != NOSIG_LIMIT
    ##1 (state == ST_MEASURE && !ref_fall) [*8]
    |=> state != ST_MEASURE || cnt == $past(cnt, 9) + 16'h0001)
    else $error("count step is not nine cycles");

  step_hold_a: assert property (
    state == ST_MEASURE && !ref_fall && pre != STEP_LAST
    |=> cnt == $past(cnt))
    else $error("count moved inside a step");

  noref_a: assert property (
    (state == ST_SYNC || state == ST_WAIT_HIGH) && nosig
    |=> done && status == STAT_NOREF && state == ST_IDLE)
    else $error("no-signal limit did not abort");

  clear_edge_a: assert property (
    state == ST_SYNC && ref_fall && !nosig |=> cnt == COUNT_ZERO)
    else $error("counter not cleared at edge");

  low_fail_a: assert property (
    state == ST_MEASURE && ref_fall
    && cnt <= limits.lower_count_limit |=> status == STAT_RANGE)
    else $error("low count not flagged");

  high_fail_a: assert property (
    state == ST_MEASURE && ref_fall
    && cnt > limits.upper_count_limit |=> status == STAT_RANGE)
    else $error("high count not flagged");

  pass_code_a: assert property (
    state == ST_MEASURE && ref_fall && cnt > limits.lower_count_limit
    && cnt <= limits.upper_count_limit |=> status == STAT_PASS)
    else $error("in-window count not passed");

  noref_distinct_a: assert property (
    done && status == STAT_NOREF |-> $past(state) != ST_MEASURE)
    else $error("no-reference status from a measurement");

  idle_hold_a: assert property (
    state == ST_IDLE && !start |=> state == ST_IDLE && !done)
    else $error("left idle without start");

  pass_seen_c: cover property (done && status == STAT_PASS);
  range_seen_c: cover property (done && status == STAT_RANGE);
  noref_seen_c: cover property (done && status == STAT_NOREF);
  restart_c: cover property (done ##1 start);

endmodule : clock_period_monitor

// ===== verif/ref_source.sv
// behavioural reference source driving the monitor's input pin
`timescale 1ns/10ps
module ref_source (
  input  wire logic        en,      // run the square wave
  input  wire logic [15:0] half_ns, // length of each phase in ns
  output logic             pin      // reference level
);
  // square wave while enabled; when stopped, the running phase still ends with one toggle, then the level is frozen
  initial begin
    pin = 1'b1;
    #3;
    forever begin
      if (en) begin
        #(half_ns) pin = ~pin;
      end else begin
        #10;
      end
    end
  end
endmodule : ref_source

// ===== verif/clock_period_monitor_test.sv
// self-checking bench of the clock period monitor
`timescale 1ns/10ps
module clock_period_monitor_test;
  import clock_monitor_pkg::*;
  localparam logic [15:0] NOSIG = 16'h0200; // shortened wait limit
  localparam int HALF = 9 * 20 + 4;         // high phase in cycles
  logic    core_clk   = 1'b0;
  logic    arst_n     = 1'b0;
  logic    start      = 1'b0;
  limits_t limits     = '0;
  logic    ref_en     = 1'b0;
  logic    pin;
  logic    busy;
  result_t result;
  int      n_mismatch = 0;
  int      num_checks = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  // reference partner and monitor
  ref_source src (.en(ref_en), .half_ns(16'(HALF * 10)), .pin(pin));
  clock_period_monitor #(.NOSIG_CYCLES(NOSIG)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .start(start),
    .limits(limits), .reference_input_pin(pin),
    .busy(busy), .result(result));

  // compare helpers, one per result kind
  task automatic chk_bit(input string w, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask : chk_bit
  task automatic chk_stat(input string w, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask : chk_stat
  task automatic chk_cnt(input string w, input logic [15:0] e,
                         input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask : chk_cnt

  // verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // one measurement: limits, start pulse, bounded wait for done
  task automatic run(input logic [15:0] lo, input logic [15:0] hi,
                     output int n);
    limits = '{lower_count_limit: lo, upper_count_limit: hi};
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    chk_bit("busy_on", 1'b1, busy);
    n = 0;
    while (result.done !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit("done", 1'b1, result.done);
    chk_bit("busy_off", 1'b0, busy);
  endtask : run

  // outputs while reset is held
  task automatic t_reset;
    chk_bit("busy", 1'b0, busy);
    chk_bit("done", 1'b0, result.done);
    chk_stat("status", STAT_PASS, result.status);
    chk_cnt("count", 16'h0000, result.count);
  endtask : t_reset

  // reset in mid-measurement returns the outputs to reset values
  task automatic t_midreset;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (250) @(negedge core_clk);
    chk_bit("busy_mid", 1'b1, busy);
    arst_n = 1'b0;
    @(negedge core_clk);
    chk_bit("busy_rst", 1'b0, busy);
    chk_bit("done_rst", 1'b0, result.done);
    chk_stat("status_rst", STAT_PASS, result.status);
    chk_cnt("count_rst", 16'h0000, result.count);
    arst_n = 1'b1;
  endtask : t_midreset

  // count 20 with lower 19, upper 20 passes, then stays idle
  task automatic t_pass;
    int n;
    run(16'h0013, 16'h0014, n);
    chk_stat("status", STAT_PASS, result.status);
    chk_cnt("count", 16'h0014, result.count);
    @(negedge core_clk);
    chk_bit("done_pulse", 1'b0, result.done);
    repeat (300) @(negedge core_clk);
    chk_bit("idle", 1'b0, busy);
  endtask : t_pass

  // count equal to lower limit fails
  task automatic t_low;
    int n;
    run(16'h0014, 16'h0020, n);
    chk_stat("status", STAT_RANGE, result.status);
    chk_cnt("count", 16'h0014, result.count);
  endtask : t_low

  // count one above upper limit fails
  task automatic t_high;
    int n;
    run(16'h0010, 16'h0013, n);
    chk_stat("status", STAT_RANGE, result.status);
  endtask : t_high

  // frozen reference aborts after the wait limit
  task automatic t_noref;
    int n;
    ref_en = 1'b0;
    run(16'h0013, 16'h0014, n);
    chk_stat("status", STAT_NOREF, result.status);
    chk_cnt("wait_len", NOSIG + 16'h0001, 16'(n));
    chk_cnt("noref_count", NOSIG, result.count);
  endtask : t_noref

  // one last fall, then a reference frozen low aborts in the rise wait
  task automatic t_noref_low;
    int n;
    ref_en = 1'b1;
    repeat (20) @(negedge core_clk);
    ref_en = 1'b0;
    run(16'h0013, 16'h0014, n);
    chk_stat("status_low", STAT_NOREF, result.status);
    chk_cnt("low_count", NOSIG, result.count);
    chk_bit("low_wait_len", 1'b1, n > int'(NOSIG) + 1);
  endtask : t_noref_low

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    t_reset;
    arst_n = 1'b1;
    ref_en = 1'b1;
    t_pass;
    t_midreset;
    t_low;
    t_high;
    t_noref;
    t_noref_low;
    summarize;
  end

  // watchdog far beyond the five measurements
  initial begin
    #200000;
    n_mismatch++;
    summarize;
  end
endmodule : clock_period_monitor_test
